// ==== logic/power_mode_controller.sv ====
/*
  Power-mode controller: idle, stop, suspend and shutdown sequencing,
  power control and regulator registers on the special-function port.
  Assumes the CPU pulses insn_done when the writing instruction ends,
  and that a system reset controller acts on reset_req_r and por_req_r.
*/
// Summary of operation
// - Idle request halts CPU after instruction
// - Enabled interrupt in idle clears request, resumes
// - Idle wake resumes at following instruction
// - Reset ends idle with restart at zero
// - Watchdog expiry during idle forces reset
// - Stop request halts CPU and all clocks
// - Only reset ends stop, restart at zero
// - Missing-clock reset ends stop when enabled
// - Suspend on fast oscillator halts it
// - Enabled wake ends suspend, resume next instruction
// - Reset ends suspend with restart at zero
// - Shutdown halts CPU, core regulator off, pins held
// - Only pin or power cycle wakes shutdown
// - Regulator controls reset to normal mode
// - Low-bias alone selects reduced-bias mode
// - Bias-off disables bias; plus off kills regulator
// - Stop and idle bits read zero
// - Six scratch flags, read-write, reset zero
// - Halt-cuts-power chooses aux regulator stop behaviour
// - Bus-supply status mirrors the supply detect
module power_mode_controller
  import power_mode_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata_r,
  input wire logic insn_done,
  input wire logic irq_pending,
  input wire logic suspend_set,
  input wire logic system_clock_net_is_hfosc,
  input wire logic wake_event,
  input wire logic wdt_expire,
  input wire logic mcd_reset,
  input wire logic reset_pin_n,
  input wire logic power_cycle,
  input wire logic bus_supply_pin,
  output logic cpu_halt_r,
  output logic clocks_stopped_r,
  output logic hfosc_halt_r,
  output logic core_ldo_off_r,
  output logic aux_reg_shutdown_r,
  output logic io_hold_r,
  output logic resume_r,
  output logic reset_req_r,
  output logic por_req_r,
  output logic [15:0] reset_vector_r,
  output logic usb_reg_disable_r,
  output logic usb_reg_low_power_r,
  output logic aux_reg_low_power_r,
  output power_mode_pkg::reg_mode_type reg_mode_r
);

  // ************************************************************
  // Declarations
  // ************************************************************
  power_mode_type state_r;
  power_mode_type state_nxt;
  logic [PC_FLAG_W-1:0] scratch_r;
  logic idle_pend_r;
  logic stop_pend_r;
  logic susp_pend_r;
  logic halt_cuts_power_cfg_r;
  logic [2:0] aux_ctrl_r;
  logic [PIN_LANES-1:0] pins_r;
  logic pin_rst;
  logic pwr_rst;
  logic rst_any;
  logic enter;
  logic wake;
  logic take_reset;
  logic take_por;
  logic wr_pc;
  logic wr_rc;
  logic wr_ar;

  assign pin_rst = !pins_r[LANE_RESET_PIN_N];
  assign pwr_rst = pins_r[LANE_POWER_CYCLE];
  assign rst_any = wdt_expire || mcd_reset || pin_rst || pwr_rst;
  assign wr_pc = sfr_wr && (sfr_addr == POWER_CONTROL_ADDR);
  assign wr_rc = sfr_wr && (sfr_addr == REGULATOR_CONTROL_ADDR);
  assign wr_ar = sfr_wr && (sfr_addr == AUX_REG_CONTROL_ADDR);

  // ************************************************************
  // Helpers
  // ************************************************************
  pin_sync #(
    .WIDTH(PIN_LANES),
    .IDLE(PIN_IDLE_LEVELS)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_in({power_cycle, bus_supply_pin, reset_pin_n}),
    .level_r(pins_r)
  );

  reg_mode_decode u_reg_mode (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .low_bias(aux_ctrl_r[AR_LOW_BIAS_BIT]),
    .bias_off(aux_ctrl_r[AR_BIAS_OFF_BIT]),
    .reg_off(aux_ctrl_r[AR_REG_OFF_BIT]),
    .mode_r(reg_mode_r)
  );

  // ************************************************************
  // Mode sequencer
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    enter = 1'b0;
    wake = 1'b0;
    take_reset = 1'b0;
    take_por = 1'b0;
    case (state_r)
      MODE_NORMAL: begin
        if (rst_any) begin
          take_reset = 1'b1;
        end else if (insn_done && stop_pend_r) begin
          enter = 1'b1;
          state_nxt = halt_cuts_power_cfg_r ? MODE_SHUTDOWN : MODE_STOP;
        end else if (insn_done && idle_pend_r) begin
          enter = 1'b1;
          state_nxt = MODE_IDLE;
        end else if (insn_done && susp_pend_r) begin
          enter = 1'b1;
          // Suspend is dropped unless the fast oscillator drives the clock
          if (system_clock_net_is_hfosc) begin
            state_nxt = MODE_SUSPEND;
          end
        end
      end
      MODE_IDLE: begin
        if (rst_any) begin
          take_reset = 1'b1;
          state_nxt = MODE_NORMAL;
        end else if (irq_pending) begin
          wake = 1'b1;
          state_nxt = MODE_NORMAL;
        end
      end
      MODE_STOP: begin
        // Wake events are ignored here; only a reset ends stop
        if (rst_any) begin
          take_reset = 1'b1;
          state_nxt = MODE_NORMAL;
        end
      end
      MODE_SUSPEND: begin
        if (rst_any) begin
          take_reset = 1'b1;
          state_nxt = MODE_NORMAL;
        end else if (wake_event) begin
          wake = 1'b1;
          state_nxt = MODE_NORMAL;
        end
      end
      MODE_SHUTDOWN: begin
        // Watchdog and missing-clock are powered down here
        if (pin_rst || pwr_rst) begin
          take_por = 1'b1;
          state_nxt = MODE_NORMAL;
        end
      end
      default: begin
        state_nxt = MODE_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= MODE_NORMAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // Pending requests; a new write wins over a same-cycle clear
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      idle_pend_r <= 1'b0;
      stop_pend_r <= 1'b0;
      susp_pend_r <= 1'b0;
    end else begin
      if (wr_pc && sfr_wdata[PC_IDLE_BIT]) begin
        idle_pend_r <= 1'b1;
      end else if (enter || wake || take_reset || take_por) begin
        idle_pend_r <= 1'b0;
      end
      if (wr_pc && sfr_wdata[PC_STOP_BIT]) begin
        stop_pend_r <= 1'b1;
      end else if (enter || take_reset || take_por) begin
        stop_pend_r <= 1'b0;
      end
      if (suspend_set) begin
        susp_pend_r <= 1'b1;
      end else if (enter || wake || take_reset || take_por) begin
        susp_pend_r <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Power outputs, from the next state so they track it exactly
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cpu_halt_r <= 1'b0;
      clocks_stopped_r <= 1'b0;
      hfosc_halt_r <= 1'b0;
      core_ldo_off_r <= 1'b0;
      aux_reg_shutdown_r <= 1'b0;
      io_hold_r <= 1'b0;
    end else begin
      cpu_halt_r <= (state_nxt != MODE_NORMAL);
      // Idle keeps clocks so the watchdog keeps counting
      clocks_stopped_r <= (state_nxt == MODE_STOP) ||
                          (state_nxt == MODE_SUSPEND) ||
                          (state_nxt == MODE_SHUTDOWN);
      hfosc_halt_r <= (state_nxt == MODE_SUSPEND);
      core_ldo_off_r <= (state_nxt == MODE_SHUTDOWN);
      aux_reg_shutdown_r <= (state_nxt == MODE_SHUTDOWN);
      io_hold_r <= (state_nxt == MODE_SHUTDOWN);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      resume_r <= 1'b0;
      reset_req_r <= 1'b0;
      por_req_r <= 1'b0;
      reset_vector_r <= RESET_VECTOR;
    end else begin
      resume_r <= wake;
      reset_req_r <= take_reset;
      por_req_r <= take_por;
      reset_vector_r <= RESET_VECTOR;
    end
  end

  // ************************************************************
  // Register writes
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      scratch_r <= POWER_CONTROL_RST[PC_FLAG_LSB +: PC_FLAG_W];
    end else if (wr_pc) begin
      scratch_r <= sfr_wdata[PC_FLAG_LSB +: PC_FLAG_W];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      usb_reg_disable_r <= REGULATOR_CONTROL_RST[RC_USB_DIS_BIT];
      usb_reg_low_power_r <= REGULATOR_CONTROL_RST[RC_USB_LP_BIT];
      halt_cuts_power_cfg_r <= REGULATOR_CONTROL_RST[RC_HALT_CUTS_BIT];
      aux_reg_low_power_r <= REGULATOR_CONTROL_RST[RC_USB_AUX_LP_BIT];
    end else if (wr_rc) begin
      usb_reg_disable_r <= sfr_wdata[RC_USB_DIS_BIT];
      usb_reg_low_power_r <= sfr_wdata[RC_USB_LP_BIT];
      halt_cuts_power_cfg_r <= sfr_wdata[RC_HALT_CUTS_BIT];
      aux_reg_low_power_r <= sfr_wdata[RC_USB_AUX_LP_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aux_ctrl_r <= AUX_REG_CONTROL_RST;
    end else if (wr_ar) begin
      aux_ctrl_r <= sfr_wdata[2:0];
    end
  end

  // ************************************************************
  // Register reads, one cycle after the address
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_addr == POWER_CONTROL_ADDR) begin
      sfr_rdata_r <= {scratch_r, 2'b00};
    end else if (sfr_addr == REGULATOR_CONTROL_ADDR) begin
      sfr_rdata_r <= {usb_reg_disable_r, pins_r[LANE_BUS_SUPPLY], 1'b0,
                      usb_reg_low_power_r, halt_cuts_power_cfg_r, 1'b0,
                      aux_reg_low_power_r, 1'b0};
    end else if (sfr_addr == AUX_REG_CONTROL_ADDR) begin
      sfr_rdata_r <= {5'h00, aux_ctrl_r};
    end else begin
      sfr_rdata_r <= 8'h00;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_idle_entry;
    (state_r == MODE_NORMAL && insn_done && idle_pend_r && !stop_pend_r &&
     !rst_any) |=> (state_r == MODE_IDLE && cpu_halt_r && !clocks_stopped_r);
  endproperty
  a_idle_entry: assert property (p_idle_entry)
    else $error("idle not entered after request");

  property p_idle_wake;
    (state_r == MODE_IDLE && irq_pending && !rst_any) |=>
      (resume_r && !cpu_halt_r && !reset_req_r) ##1 !resume_r;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("interrupt did not resume from idle");

  property p_resume_no_restart;
    resume_r |-> (!reset_req_r && !por_req_r && !cpu_halt_r);
  endproperty
  a_resume_no_restart: assert property (p_resume_no_restart)
    else $error("resume combined with restart");

  property p_reset_wins;
    ((state_r == MODE_IDLE || state_r == MODE_SUSPEND) && rst_any) |=>
      (reset_req_r && !resume_r && reset_vector_r == RESET_VECTOR);
  endproperty
  a_reset_wins: assert property (p_reset_wins)
    else $error("reset did not beat wake");

  property p_wdt_idle;
    (state_r == MODE_IDLE && wdt_expire) |=> reset_req_r;
  endproperty
  a_wdt_idle: assert property (p_wdt_idle)
    else $error("watchdog did not end idle");

  property p_stop_hold;
    (state_r == MODE_STOP && !rst_any) |=>
      (state_r == MODE_STOP && clocks_stopped_r && cpu_halt_r);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stop left without reset");

  property p_mcd_stop;
    (state_r == MODE_STOP && mcd_reset) |=>
      (reset_req_r && state_r == MODE_NORMAL);
  endproperty
  a_mcd_stop: assert property (p_mcd_stop)
    else $error("missing clock did not end stop");

  property p_shutdown_hold;
    (state_r == MODE_SHUTDOWN && !pin_rst && !pwr_rst) |=>
      (state_r == MODE_SHUTDOWN && io_hold_r && core_ldo_off_r &&
       !reset_req_r);
  endproperty
  a_shutdown_hold: assert property (p_shutdown_hold)
    else $error("shutdown left without pin or power cycle");

  property p_readback_zero;
    (sfr_addr == POWER_CONTROL_ADDR) |=> (sfr_rdata_r[1:0] == 2'b00 &&
      sfr_rdata_r[7:2] == $past(scratch_r));
  endproperty
  a_readback_zero: assert property (p_readback_zero)
    else $error("power control readback wrong");

  c_idle_wake: cover property (state_r == MODE_IDLE ##1 resume_r);
  c_suspend_wake: cover property (state_r == MODE_SUSPEND ##1 resume_r);
  c_stop_reset: cover property (state_r == MODE_STOP ##1 reset_req_r);
  c_shutdown_por: cover property (state_r == MODE_SHUTDOWN ##1 por_req_r);

endmodule

// ==== logic/power_mode_pkg.sv ====
/*
  Constants and types shared by the power-mode controller and its helpers.
  Assumes an 8-bit special-function register port driven by the CPU core.
*/
package power_mode_pkg;

  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] REGULATOR_CONTROL_ADDR = 8'hc9;
  localparam logic [7:0] AUX_REG_CONTROL_ADDR = 8'hca;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
  localparam logic [7:0] REGULATOR_CONTROL_RST = 8'h00;
  localparam logic [2:0] AUX_REG_CONTROL_RST = 3'h0;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int PC_IDLE_BIT = 0;
  localparam int PC_STOP_BIT = 1;
  localparam int PC_FLAG_LSB = 2;
  localparam int PC_FLAG_W = 6;
  localparam int RC_USB_AUX_LP_BIT = 1;
  localparam int RC_HALT_CUTS_BIT = 3;
  localparam int RC_USB_LP_BIT = 4;
  localparam int RC_BUS_PRESENT_BIT = 6;
  localparam int RC_USB_DIS_BIT = 7;
  localparam int AR_LOW_BIAS_BIT = 0;
  localparam int AR_BIAS_OFF_BIT = 1;
  localparam int AR_REG_OFF_BIT = 2;

  // ************************************************************
  // Pin synchroniser lanes and their idle levels
  // ************************************************************
  localparam int PIN_LANES = 3;
  localparam int LANE_RESET_PIN_N = 0;
  localparam int LANE_BUS_SUPPLY = 1;
  localparam int LANE_POWER_CYCLE = 2;
  localparam logic [2:0] PIN_IDLE_LEVELS = 3'h1;

  // ************************************************************
  // Enumerations
  // ************************************************************
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_IDLE,
    MODE_STOP,
    MODE_SUSPEND,
    MODE_SHUTDOWN
  } power_mode_type;

  typedef enum logic [1:0] {
    REG_NORMAL,
    REG_LOW_BIAS,
    REG_BIAS_OFF,
    REG_OFF
  } reg_mode_type;

endpackage

// ==== logic/pin_sync.sv ====
/*
  Three-stage synchroniser for a group of slow pin levels.
  Assumes the pins are asynchronous to clk_sys and change slowly.
*/
module pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_r
);

  // ************************************************************
  // Per-lane stages
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_lane
      logic s1_r;
      logic s2_r;
      logic s3_r;
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          s1_r <= IDLE[i];
          s2_r <= IDLE[i];
          s3_r <= IDLE[i];
          level_r[i] <= IDLE[i];
        end else begin
          s1_r <= pin_in[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          // Only accept a level once two late stages agree
          if (s2_r == s3_r) begin
            level_r[i] <= s3_r;
          end
        end
      end
    end
  endgenerate

endmodule

// ==== logic/reg_mode_decode.sv ====
/*
  Decodes the three regulator control bits into a regulator mode.
  Assumes the control bits come from registers on the same clock.
*/
module reg_mode_decode
  import power_mode_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic low_bias,
  input wire logic bias_off,
  input wire logic reg_off,
  output power_mode_pkg::reg_mode_type mode_r
);

  // ************************************************************
  // Mode select
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_r <= REG_NORMAL;
    end else if (bias_off && reg_off) begin
      mode_r <= REG_OFF;
    end else if (bias_off) begin
      mode_r <= REG_BIAS_OFF;
    end else if (low_bias) begin
      mode_r <= REG_LOW_BIAS;
    end else begin
      // Regulator-off without bias-off is not a listed mode
      mode_r <= REG_NORMAL;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_reg_decode;
    @(posedge clk_sys) disable iff (sys_rst)
    (low_bias && !bias_off && !reg_off) |=> (mode_r == REG_LOW_BIAS);
  endproperty
  a_reg_decode: assert property (p_reg_decode)
    else $error("low-bias selection not decoded");

endmodule

// ==== bench/cpu_model.sv ====
/*
  Model of the CPU core: special-function writes, reads and instruction
  end pulses. Assumes the controller samples on the rising clk_sys edge.
*/
module cpu_model (
  input wire logic clk_sys,
  input wire logic [7:0] sfr_rdata_r,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic [7:0] sfr_wdata,
  output logic insn_done
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    insn_done = 1'b0;
  end

  // ************
  // Bus cycles
  // ************
  // A mode write is followed by a two-byte opcode, so at most one
  // end pulse is given, only when e is set, and no later wake is lost
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic e);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    insn_done <= e;
    @(posedge clk_sys);
    insn_done <= 1'b0;
  endtask

  task automatic ins();
    @(posedge clk_sys);
    insn_done <= 1'b1;
    @(posedge clk_sys);
    insn_done <= 1'b0;
  endtask

  // Read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    @(posedge clk_sys);
    #1;
    d = sfr_rdata_r;
  endtask
endmodule

// ==== bench/tb_power_mode_controller.sv ====
/*
  Self-checking bench for the power-mode controller.
  Assumes the CPU model in cpu_model.sv and a 50 MHz clk_sys.
*/
module tb_power_mode_controller;
  import power_mode_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic irq_pending = 1'b0;
  logic suspend_set = 1'b0;
  logic system_clock_net_is_hfosc = 1'b1;
  logic wake_event = 1'b0;
  logic wdt_expire = 1'b0;
  logic mcd_reset = 1'b0;
  logic reset_pin_n = 1'b1;
  logic power_cycle = 1'b0;
  logic bus_supply_pin = 1'b0;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_r;
  logic sfr_wr, insn_done, cpu_halt_r, clocks_stopped_r, hfosc_halt_r;
  logic core_ldo_off_r, aux_reg_shutdown_r, io_hold_r, resume_r;
  logic reset_req_r, por_req_r, f;
  logic usb_reg_disable_r, usb_reg_low_power_r, aux_reg_low_power_r;
  logic [15:0] reset_vector_r;
  reg_mode_type reg_mode_r;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [7:0] ab [6] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h00};
  reg_mode_type em [6] = '{REG_LOW_BIAS, REG_BIAS_OFF, REG_BIAS_OFF,
                           REG_OFF, REG_OFF, REG_NORMAL};

  always #10 clk_sys = ~clk_sys;

  cpu_model cpu_model_i (
    .clk_sys(clk_sys), .sfr_rdata_r(sfr_rdata_r), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .insn_done(insn_done));

  power_mode_controller power_mode_controller_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r),
    .insn_done(insn_done), .irq_pending(irq_pending),
    .suspend_set(suspend_set), .system_clock_net_is_hfosc(system_clock_net_is_hfosc),
    .wake_event(wake_event), .wdt_expire(wdt_expire),
    .mcd_reset(mcd_reset), .reset_pin_n(reset_pin_n),
    .power_cycle(power_cycle), .bus_supply_pin(bus_supply_pin),
    .cpu_halt_r(cpu_halt_r), .clocks_stopped_r(clocks_stopped_r),
    .hfosc_halt_r(hfosc_halt_r), .core_ldo_off_r(core_ldo_off_r),
    .aux_reg_shutdown_r(aux_reg_shutdown_r), .io_hold_r(io_hold_r),
    .resume_r(resume_r), .reset_req_r(reset_req_r),
    .por_req_r(por_req_r), .reset_vector_r(reset_vector_r),
    .usb_reg_disable_r(usb_reg_disable_r),
    .usb_reg_low_power_r(usb_reg_low_power_r),
    .aux_reg_low_power_r(aux_reg_low_power_r), .reg_mode_r(reg_mode_r));

  // ************
  // Helpers
  // ************
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A hang ends the run here rather than stalling the simulator
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    cpu_model_i.rd(a, d);
    tests_run++;
    if (d !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, d, exp);
    end
  endtask

  task automatic cy(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Bounded wait: 0 resume, 1 reset request, 2 power-on request
  task automatic wt(input int s, output logic fo);
    fo = 1'b0;
    for (int i = 0; i < 8 && !fo; i++) begin
      @(posedge clk_sys);
      #1;
      fo = (s == 0) ? resume_r : (s == 1) ? reset_req_r : por_req_r;
    end
  endtask

  // The bench stands in for the system reset controller
  task automatic do_reset();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask

  // Expects the oscillator halt only when the fast oscillator drives
  task automatic enter_suspend(input logic e);
    @(posedge clk_sys);
    suspend_set <= 1'b1;
    @(posedge clk_sys);
    suspend_set <= 1'b0;
    cpu_model_i.ins();
    cy(1);
    chk(hfosc_halt_r, {15'h0, e});
  endtask

  // ************
  // Scenarios
  // ************
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    cy(1);
    chk(reset_vector_r, 16'h0000);
    chk(16'(reg_mode_r), 16'(REG_NORMAL));
    rd(8'h87, 8'h00);
    rd(8'hca, 8'h00);
    rd(8'hc9, 8'h00);
    cpu_model_i.wr(8'h87, 8'hfc, 1'b0);
    rd(8'h87, 8'hfc);
    cpu_model_i.wr(8'h87, 8'h00, 1'b0);
    rd(8'h87, 8'h00);
    cpu_model_i.wr(8'h55, 8'hff, 1'b0);
    rd(8'h55, 8'h00);
    for (int i = 0; i < 6; i++) begin
      cpu_model_i.wr(8'hca, ab[i], 1'b0);
      cy(3);
      chk(16'(reg_mode_r), 16'(em[i]));
    end
    @(posedge clk_sys);
    bus_supply_pin <= 1'b1;
    cy(6);
    rd(8'hc9, 8'h40);
    cpu_model_i.wr(8'hc9, 8'hff, 1'b0);
    rd(8'hc9, 8'hda);
    chk(usb_reg_disable_r, 16'h1);
    chk(usb_reg_low_power_r, 16'h1);
    chk(aux_reg_low_power_r, 16'h1);
    cpu_model_i.wr(8'hc9, 8'h00, 1'b0);
    cpu_model_i.wr(8'h87, 8'h05, 1'b1);
    cy(1);
    chk(cpu_halt_r, 16'h1);
    chk(clocks_stopped_r, 16'h0);
    rd(8'h87, 8'h04);
    @(posedge clk_sys);
    irq_pending <= 1'b1;
    wt(0, f);
    chk(f, 16'h1);
    chk(cpu_halt_r, 16'h0);
    @(posedge clk_sys);
    irq_pending <= 1'b0;
    cpu_model_i.wr(8'h87, 8'h01, 1'b1);
    cy(1);
    @(posedge clk_sys);
    wdt_expire <= 1'b1;
    wt(1, f);
    chk(f, 16'h1);
    chk(cpu_halt_r, 16'h0);
    @(posedge clk_sys);
    wdt_expire <= 1'b0;
    do_reset();
    cpu_model_i.wr(8'h87, 8'h02, 1'b1);
    cy(1);
    chk(clocks_stopped_r, 16'h1);
    chk(aux_reg_shutdown_r, 16'h0);
    @(posedge clk_sys);
    wake_event <= 1'b1;
    irq_pending <= 1'b1;
    cy(5);
    chk(cpu_halt_r, 16'h1);
    @(posedge clk_sys);
    wake_event <= 1'b0;
    irq_pending <= 1'b0;
    mcd_reset <= 1'b1;
    wt(1, f);
    chk(f, 16'h1);
    @(posedge clk_sys);
    mcd_reset <= 1'b0;
    do_reset();
    cpu_model_i.wr(8'hc9, 8'h08, 1'b0);
    cpu_model_i.wr(8'h87, 8'h02, 1'b1);
    cy(1);
    chk(io_hold_r, 16'h1);
    chk(core_ldo_off_r, 16'h1);
    chk(aux_reg_shutdown_r, 16'h1);
    @(posedge clk_sys);
    wdt_expire <= 1'b1;
    wt(1, f);
    chk(f, 16'h0);
    @(posedge clk_sys);
    wdt_expire <= 1'b0;
    reset_pin_n <= 1'b0;
    wt(2, f);
    chk(f, 16'h1);
    cy(1);
    chk(io_hold_r, 16'h0);
    @(posedge clk_sys);
    reset_pin_n <= 1'b1;
    do_reset();
    // Reset puts the supply lane back to idle; let the synchroniser refill
    cy(5);
    rd(8'hc9, 8'h40);
    cpu_model_i.wr(8'hc9, 8'h08, 1'b0);
    cpu_model_i.wr(8'h87, 8'h02, 1'b1);
    @(posedge clk_sys);
    power_cycle <= 1'b1;
    wt(2, f);
    chk(f, 16'h1);
    @(posedge clk_sys);
    power_cycle <= 1'b0;
    do_reset();
    @(posedge clk_sys);
    system_clock_net_is_hfosc <= 1'b0;
    enter_suspend(1'b0);
    chk(cpu_halt_r, 16'h0);
    @(posedge clk_sys);
    system_clock_net_is_hfosc <= 1'b1;
    enter_suspend(1'b1);
    @(posedge clk_sys);
    wake_event <= 1'b1;
    wt(0, f);
    chk(f, 16'h1);
    @(posedge clk_sys);
    wake_event <= 1'b0;
    enter_suspend(1'b1);
    @(posedge clk_sys);
    wake_event <= 1'b1;
    wdt_expire <= 1'b1;
    wt(1, f);
    chk(f, 16'h1);
    chk(resume_r, 16'h0);
    @(posedge clk_sys);
    wake_event <= 1'b0;
    wdt_expire <= 1'b0;
    do_reset();
    cy(2);
    conclude();
  end
endmodule
